/* sso_host.sv */
// Host controller model: drives servo-on and start pins
// Assumes bench commands; pins change only after a rising edge
`timescale 1ns/1ps
module sso_host (
   // Clock
   input  wire logic i_clk,
   // Commands from the bench
   input  wire logic i_son,
   input  wire logic i_fwd,
   input  wire logic i_rev,
   // Pins into the drive
   output logic      o_son,
   output logic      o_fwd,
   output logic      o_rev
);
   always @(posedge i_clk) begin
      o_son <= i_son;
      o_fwd <= i_fwd;
      o_rev <= i_rev;
   end
endmodule

/* sso_mag.sv */
// Magnitude of a signed value, as unsigned of the same width
// Assumes a purely combinational use
`timescale 1ns/1ps
module sso_mag #(
   parameter int W = 16
) (
   // Value
   input  wire logic signed [W-1:0] i_val,
   // Magnitude
   output logic             [W-1:0] o_mag
);
   always_comb begin
      if (i_val[W-1]) begin
         o_mag = W'(-i_val);
      end else begin
         o_mag = i_val;
      end
   end
endmodule

/* sso_map.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register
`ifndef SSO_MAP_SVH
`define SSO_MAP_SVH

// Data and timing
`define SSO_DW          16
`define SSO_CLK_NS      40
`define SSO_PWRUP_NS    1000000000
`define SSO_PWRUP_CYC   ((`SSO_PWRUP_NS) / (`SSO_CLK_NS))
`define SSO_TMR_W       25
`define SSO_SLOW_RPM    16'sh0014

// Byte offsets
`define SSO_CTRL_OFS    8'h00
`define SSO_INPOS_OFS   8'h04
`define SSO_SPDSEL_OFS  8'h08
`define SSO_BAND_OFS    8'h0c
`define SSO_FTRQ_OFS    8'h10
`define SSO_RTRQ_OFS    8'h14
`define SSO_STAT_OFS    8'h18
`define SSO_ISTAT_OFS   8'h1c
`define SSO_IEN_OFS     8'h20
`define SSO_ICLR_OFS    8'h24
`define SSO_SLIM_OFS    8'h40

// Control fields
`define SSO_CTRL_MODE   1:0
`define SSO_CTRL_BRKMAP 2
`define SSO_CTRL_TANA   3

// Reset values and event count
`define SSO_INPOS_RST   16'h0064
`define SSO_BAND_RST    16'h000a
`define SSO_TRQ_RST     16'h7fff
`define SSO_SLIM_RST    16'h0bb8
`define SSO_NEV         5
`endif

/* sso_pkg.sv */
// Types shared by the servo status output block
// Assumes sso_map.svh is on the include path
`include "sso_map.svh"
package sso_pkg;
   typedef enum logic [1:0] {MODE_POS, MODE_SPD, MODE_TRQ} sso_mode_t;

   typedef struct packed {
      sso_mode_t                        mode;
      logic                             brk_map;
      logic                             trq_ana;
      logic [`SSO_DW-1:0]               inpos_rng;
      logic [2:0]                       spd_sel;
      logic [`SSO_DW-1:0]               band;
      logic [`SSO_DW-1:0]               fwd_trq;
      logic [`SSO_DW-1:0]               rev_trq;
      logic [6:0][`SSO_DW-1:0]          spd_lim;
      logic [`SSO_NEV-1:0]              irq_stat;
      logic [`SSO_NEV-1:0]              irq_en;
      logic                             irq;
      logic                             wr_pend;
      logic [7:0]                       wr_addr;
      logic [31:0]                      hrdata;
      logic                             hready;
      logic [`SSO_TMR_W-1:0]            timer;
      logic                             son_d;
      logic                             fault_free;
      logic                             brk;
      logic                             brk_oe;
      logic                             ready;
      logic                             inpos;
      logic                             spd_att;
      logic                             spd_lmt;
      logic                             trq_lmt;
   } sso_state_t;
endpackage

/* sso_status_out.sv */
// Servo drive discrete status outputs with AHB-Lite register slave
// Assumes drive state inputs on I_REF_CLK; start and servo-on from pins
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "sso_map.svh"
module sso_status_out
   import sso_pkg::*;
#(
   parameter logic [`SSO_TMR_W-1:0] PWRUP_CYC = `SSO_TMR_W'(`SSO_PWRUP_CYC)
) (
   // Clock and reset
   input  wire logic                     I_REF_CLK,
   input  wire logic                     I_NRST,
   // AHB-Lite slave
   input  wire logic                     I_HSEL,
   input  wire logic [31:0]              I_HADDR,
   input  wire logic [1:0]               I_HTRANS,
   input  wire logic                     I_HWRITE,
   input  wire logic [2:0]               I_HSIZE,
   input  wire logic [31:0]              I_HWDATA,
   input  wire logic                     I_HREADY,
   output logic      [31:0]              O_HRDATA,
   output logic                          O_HREADYOUT,
   output logic                          O_HRESP,
   output logic                          O_IRQ,
   // Pins from the host controller
   input  wire logic                     I_SERVO_ON_REQUEST,
   input  wire logic                     I_FORWARD_START,
   input  wire logic                     I_REVERSE_START,
   // Drive internal state
   input  wire logic                     I_POWER_OK,
   input  wire logic                     I_PROT_TRIP,
   input  wire logic                     I_BRAKE_REQUIRED,
   input  wire logic                     I_DRIVE_PREPARED,
   input  wire logic signed [`SSO_DW-1:0] I_DROOP,
   input  wire logic signed [`SSO_DW-1:0] I_MOTOR_SPEED,
   input  wire logic signed [`SSO_DW-1:0] I_PRESET_SPEED,
   input  wire logic signed [`SSO_DW-1:0] I_TORQUE,
   input  wire logic        [`SSO_DW-1:0] I_ANALOG_SPEED_LIMIT_IN,
   input  wire logic        [`SSO_DW-1:0] I_ANALOG_TORQUE_LIMIT_IN,
   // Status outputs
   output logic                          O_FAULT_FREE_OUT,
   output logic                          O_DYN_BRAKE_INTERLOCK,
   output logic                          O_DYN_BRAKE_INTERLOCK_OE,
   output logic                          O_READY,
   output logic                          O_IN_POSITION,
   output logic                          O_SPEED_ATTAINED,
   output logic                          O_SPEED_LIMITING,
   output logic                          O_TORQUE_LIMITING
);
   sso_state_t            r;
   sso_state_t            r_nxt;
   logic [2:0]            pins;
   logic                  servo_on_request;
   logic                  fwd;
   logic                  rev;
   logic                  pwr_ready;
   logic                  son_rise;
   logic [`SSO_DW-1:0]    droop_mag;
   logic [`SSO_DW-1:0]    speed_mag;
   logic [`SSO_DW-1:0]    preset_mag;
   logic [`SSO_DW-1:0]    trq_mag;
   logic [`SSO_DW:0]      diff_mag;
   logic signed [`SSO_DW:0] diff;
   logic [`SSO_DW-1:0]    spd_limit;
   logic [`SSO_DW-1:0]    trq_limit;
   logic                  addr_ok;
   logic [`SSO_NEV-1:0]   events;
   logic [`SSO_NEV-1:0]   clr_mask;
   logic [6:0]            out_vec;

   // Pin synchronisers
   sso_sync #(
      .W (3)
   ) u_sync (
      .i_clk  (I_REF_CLK),
      .i_nrst (I_NRST),
      .i_d    ({I_REVERSE_START, I_FORWARD_START, I_SERVO_ON_REQUEST}),
      .o_q    (pins)
   );

   // Magnitudes
   sso_mag #(.W(`SSO_DW)) u_mag_droop (.i_val(I_DROOP),        .o_mag(droop_mag));
   sso_mag #(.W(`SSO_DW)) u_mag_speed (.i_val(I_MOTOR_SPEED),  .o_mag(speed_mag));
   sso_mag #(.W(`SSO_DW)) u_mag_pre   (.i_val(I_PRESET_SPEED), .o_mag(preset_mag));
   sso_mag #(.W(`SSO_DW)) u_mag_trq   (.i_val(I_TORQUE),       .o_mag(trq_mag));
   sso_mag #(.W(`SSO_DW+1)) u_mag_diff (.i_val(diff),          .o_mag(diff_mag));

   assign servo_on_request = pins[0];
   assign fwd = pins[1];
   assign rev = pins[2];
   assign diff = {I_MOTOR_SPEED[`SSO_DW-1], I_MOTOR_SPEED}
               - {I_PRESET_SPEED[`SSO_DW-1], I_PRESET_SPEED};
   assign addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;
   assign out_vec = {r.trq_lmt, r.spd_lmt, r.spd_att, r.inpos, r.ready, r.brk, r.fault_free};

   // Read data for an address phase
   function automatic logic [31:0] read_word(input logic [7:0] a, input sso_state_t s,
                                             input logic [6:0] ov);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         `SSO_CTRL_OFS:   d = {28'h0000000, s.trq_ana, s.brk_map, s.mode};
         `SSO_INPOS_OFS:  d = {16'h0000, s.inpos_rng};
         `SSO_SPDSEL_OFS: d = {29'h00000000, s.spd_sel};
         `SSO_BAND_OFS:   d = {16'h0000, s.band};
         `SSO_FTRQ_OFS:   d = {16'h0000, s.fwd_trq};
         `SSO_RTRQ_OFS:   d = {16'h0000, s.rev_trq};
         `SSO_STAT_OFS:   d = {25'h0000000, ov};
         `SSO_ISTAT_OFS:  d = {27'h0000000, s.irq_stat};
         `SSO_IEN_OFS:    d = {27'h0000000, s.irq_en};
         default: begin
            if (a[7:5] == 3'h2 && a[4:2] != 3'h7 && a[1:0] == 2'h0) begin
               d = {16'h0000, s.spd_lim[a[4:2]]};
            end
         end
      endcase
      return d;
   endfunction

   always_comb begin
      r_nxt    = r;
      clr_mask = '0;

      // Bus address phase
      r_nxt.hready = 1'b1;
      r_nxt.wr_pend = addr_ok && I_HWRITE;
      r_nxt.wr_addr = I_HADDR[7:0];
      if (addr_ok && !I_HWRITE) begin
         r_nxt.hrdata = read_word(I_HADDR[7:0], r, out_vec);
      end

      // Bus data phase writes
      if (r.wr_pend) begin
         case (r.wr_addr)
            `SSO_CTRL_OFS: begin
               if (I_HWDATA[`SSO_CTRL_MODE] != 2'h3) begin
                  r_nxt.mode = sso_mode_t'(I_HWDATA[`SSO_CTRL_MODE]);
               end
               r_nxt.brk_map = I_HWDATA[`SSO_CTRL_BRKMAP];
               r_nxt.trq_ana = I_HWDATA[`SSO_CTRL_TANA];
            end
            `SSO_INPOS_OFS:  r_nxt.inpos_rng = I_HWDATA[`SSO_DW-1:0];
            `SSO_SPDSEL_OFS: r_nxt.spd_sel   = I_HWDATA[2:0];
            `SSO_BAND_OFS:   r_nxt.band      = I_HWDATA[`SSO_DW-1:0];
            `SSO_FTRQ_OFS:   r_nxt.fwd_trq   = I_HWDATA[`SSO_DW-1:0];
            `SSO_RTRQ_OFS:   r_nxt.rev_trq   = I_HWDATA[`SSO_DW-1:0];
            `SSO_IEN_OFS:    r_nxt.irq_en    = I_HWDATA[`SSO_NEV-1:0];
            `SSO_ICLR_OFS:   clr_mask        = I_HWDATA[`SSO_NEV-1:0];
            default: begin
               if (r.wr_addr[7:5] == 3'h2 && r.wr_addr[4:2] != 3'h7
                   && r.wr_addr[1:0] == 2'h0) begin
                  r_nxt.spd_lim[r.wr_addr[4:2]] = I_HWDATA[`SSO_DW-1:0];
               end
            end
         endcase
      end

      // Power-on timer
      if (!I_POWER_OK) begin
         r_nxt.timer = '0;
      end else if (r.timer != PWRUP_CYC) begin
         r_nxt.timer = r.timer + `SSO_TMR_W'(1);
      end
      pwr_ready = (r.timer == PWRUP_CYC);

      r_nxt.fault_free = I_POWER_OK && !I_PROT_TRIP && pwr_ready;

      r_nxt.brk = !I_BRAKE_REQUIRED;
      r_nxt.brk_oe = r.brk_map;

      r_nxt.ready = servo_on_request && I_DRIVE_PREPARED && r_nxt.fault_free;

      son_rise = servo_on_request && !r.son_d;
      r_nxt.son_d = servo_on_request;

      r_nxt.inpos = (r.mode == MODE_POS) && servo_on_request
                  && (son_rise
                      || droop_mag <= r.inpos_rng);

      r_nxt.spd_att = (r.mode == MODE_SPD) && servo_on_request
                    && ((preset_mag <= `SSO_SLOW_RPM)
                        || ((fwd || rev)
                            && diff_mag <= {1'b0, r.band}));

      if (r.spd_sel == 3'h0) begin
         spd_limit = I_ANALOG_SPEED_LIMIT_IN;
      end else begin
         spd_limit = r.spd_lim[r.spd_sel - 3'h1];
      end
      r_nxt.spd_lmt = (r.mode == MODE_TRQ)
                    && servo_on_request
                    && speed_mag >= spd_limit;

      if (r.trq_ana) begin
         trq_limit = I_ANALOG_TORQUE_LIMIT_IN;
      end else if (I_TORQUE[`SSO_DW-1]) begin
         trq_limit = r.rev_trq;
      end else begin
         trq_limit = r.fwd_trq;
      end
      r_nxt.trq_lmt = (r.mode != MODE_TRQ)
                    && trq_mag >= trq_limit;

      // Interrupt events, set wins over clear
      events = {r_nxt.trq_lmt && !r.trq_lmt,
                r_nxt.spd_lmt && !r.spd_lmt,
                r_nxt.spd_att && !r.spd_att,
                r_nxt.inpos && !r.inpos,
                r.fault_free && !r_nxt.fault_free};
      r_nxt.irq_stat = (r.irq_stat & ~clr_mask) | events;
      r_nxt.irq = |(r_nxt.irq_stat & r_nxt.irq_en);
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         r           <= '0;
         r.hready    <= 1'b1;
         r.brk       <= 1'b1;
         r.inpos_rng <= `SSO_INPOS_RST;
         r.band      <= `SSO_BAND_RST;
         r.fwd_trq   <= `SSO_TRQ_RST;
         r.rev_trq   <= `SSO_TRQ_RST;
         r.spd_lim   <= {7{`SSO_SLIM_RST}};
      end else begin
         r <= r_nxt;
      end
   end

   // Outputs
   assign O_HRDATA                 = r.hrdata;
   assign O_HREADYOUT              = r.hready;
   assign O_HRESP                  = 1'b0;
   assign O_IRQ                    = r.irq;
   assign O_FAULT_FREE_OUT         = r.fault_free;
   assign O_DYN_BRAKE_INTERLOCK    = r.brk;
   assign O_DYN_BRAKE_INTERLOCK_OE = r.brk_oe;
   assign O_READY                  = r.ready;
   assign O_IN_POSITION            = r.inpos;
   assign O_SPEED_ATTAINED         = r.spd_att;
   assign O_SPEED_LIMITING         = r.spd_lmt;
   assign O_TORQUE_LIMITING        = r.trq_lmt;

   // Checks
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_NRST);

   ff_power_off_a: assert property (!I_POWER_OK || I_PROT_TRIP |=> !O_FAULT_FREE_OUT)
      else $error("fault-free stayed on without power");

   ff_power_up_a: assert property (
      I_POWER_OK && !I_PROT_TRIP && r.timer == PWRUP_CYC |=> O_FAULT_FREE_OUT)
      else $error("fault-free late after power-on");

   ff_rise_a: assert property (
      $rose(O_FAULT_FREE_OUT) |-> $past(r.timer) == PWRUP_CYC)
      else $error("fault-free rose before power-on delay");

   brake_follow_a: assert property (I_BRAKE_REQUIRED |=> !O_DYN_BRAKE_INTERLOCK)
      else $error("brake interlock on while braking needed");

   brake_on_a: assert property (!I_BRAKE_REQUIRED |=> O_DYN_BRAKE_INTERLOCK)
      else $error("brake interlock off while braking not needed");

   brake_map_a: assert property (!r.brk_map ##1 !r.brk_map |-> !O_DYN_BRAKE_INTERLOCK_OE)
      else $error("brake interlock driven while unmapped");

   brake_pin_a: assert property (r.brk_map |=> O_DYN_BRAKE_INTERLOCK_OE)
      else $error("brake interlock undriven once mapped");

   ready_cause_a: assert property (O_READY |-> $past(servo_on_request) && $past(I_DRIVE_PREPARED))
      else $error("ready without servo-on");

   ready_off_a: assert property (!servo_on_request || !I_DRIVE_PREPARED |=> !O_READY)
      else $error("ready on without servo-on or prepared drive");

   inpos_range_a: assert property (
      r.mode == MODE_POS && servo_on_request && droop_mag <= r.inpos_rng |=> O_IN_POSITION)
      else $error("in-position missing inside range");

   inpos_out_a: assert property (
      !son_rise && droop_mag > r.inpos_rng |=> !O_IN_POSITION)
      else $error("in-position on outside range");

   inpos_son_a: assert property (
      r.mode == MODE_POS && servo_on_request && !r.son_d |=> O_IN_POSITION)
      else $error("in-position missing at servo-on");

   spd_near_a: assert property (
      r.mode == MODE_SPD && servo_on_request && fwd && diff_mag <= {1'b0, r.band} |=> O_SPEED_ATTAINED)
      else $error("speed-attained missing near preset");

   spd_far_a: assert property (
      r.mode == MODE_SPD && diff_mag > {1'b0, r.band} && preset_mag > `SSO_SLOW_RPM
      |=> !O_SPEED_ATTAINED)
      else $error("speed-attained on far from preset");

   spd_slow_a: assert property (
      r.mode == MODE_SPD && servo_on_request && preset_mag <= `SSO_SLOW_RPM |=> O_SPEED_ATTAINED)
      else $error("speed-attained off at low preset");

   spd_off_a: assert property (!servo_on_request || (!fwd && !rev && preset_mag > `SSO_SLOW_RPM)
      |=> !O_SPEED_ATTAINED)
      else $error("speed-attained on without servo-on or start");

   slim_hit_a: assert property (
      r.mode == MODE_TRQ && servo_on_request && speed_mag >= spd_limit |=> O_SPEED_LIMITING)
      else $error("speed-limiting missing at limit");

   slim_low_a: assert property (speed_mag < spd_limit |=> !O_SPEED_LIMITING)
      else $error("speed-limiting on below limit");

   slim_off_a: assert property (!servo_on_request |=> !O_SPEED_LIMITING)
      else $error("speed-limiting on without servo-on");

   tlim_hit_a: assert property (
      r.mode != MODE_TRQ && trq_mag >= trq_limit |=> O_TORQUE_LIMITING)
      else $error("torque-limiting missing at limit");

   tlim_low_a: assert property (trq_mag < trq_limit |=> !O_TORQUE_LIMITING)
      else $error("torque-limiting on below limit");

   mode_gate_a: assert property (
      (O_IN_POSITION |-> $past(r.mode) == MODE_POS)
      and (O_TORQUE_LIMITING |-> $past(r.mode) != MODE_TRQ))
      else $error("output active in wrong mode");

   mode_spd_a: assert property (O_SPEED_ATTAINED |-> $past(r.mode) == MODE_SPD)
      else $error("speed-attained active outside speed mode");

   mode_trq_a: assert property (O_SPEED_LIMITING |-> $past(r.mode) == MODE_TRQ)
      else $error("speed-limiting active outside torque mode");
endmodule

/* sso_status_out_tb.sv */
// Self-checking bench for the servo status output block
// Assumes sso_host drives the pins and a single-slave AHB-Lite bus
`timescale 1ns/1ps
`include "sso_map.svh"
module sso_status_out_tb;
   import sso_pkg::*;
   logic               clk, nrst, hsel, hwrite, servo_on_request, fwd, rev, pwr, trip, brk, prep;
   logic        [31:0] haddr, hwdata, rdata;
   logic        [1:0]  htrans;
   logic signed [15:0] droop, spd, pre, trq;
   logic        [15:0] aspd, atrq;
   wire  logic  [31:0] hrdata;
   wire  logic         hrdy, hresp, irq, ff, dbi, dboe, rdy, inp, sa, speed_limiting, torque_limiting;
   wire  logic         p_son, p_fwd, p_rev;
   int                 fail_count, samples_checked;

   always #20 clk = ~clk;

   sso_host host (.i_clk(clk), .i_son(servo_on_request), .i_fwd(fwd), .i_rev(rev),
      .o_son(p_son), .o_fwd(p_fwd), .o_rev(p_rev));

   sso_status_out #(.PWRUP_CYC(`SSO_TMR_W'(20))) uut (
      .I_REF_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hrdy),
      .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp), .O_IRQ(irq),
      .I_SERVO_ON_REQUEST(p_son), .I_FORWARD_START(p_fwd), .I_REVERSE_START(p_rev),
      .I_POWER_OK(pwr), .I_PROT_TRIP(trip), .I_BRAKE_REQUIRED(brk),
      .I_DRIVE_PREPARED(prep), .I_DROOP(droop), .I_MOTOR_SPEED(spd),
      .I_PRESET_SPEED(pre), .I_TORQUE(trq), .I_ANALOG_SPEED_LIMIT_IN(aspd),
      .I_ANALOG_TORQUE_LIMIT_IN(atrq), .O_FAULT_FREE_OUT(ff),
      .O_DYN_BRAKE_INTERLOCK(dbi), .O_DYN_BRAKE_INTERLOCK_OE(dboe), .O_READY(rdy),
      .O_IN_POSITION(inp), .O_SPEED_ATTAINED(sa), .O_SPEED_LIMITING(speed_limiting),
      .O_TORQUE_LIMITING(torque_limiting));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task final_report;
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Bounded wait for hready sampled high at a rising edge
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hrdy !== 1'b1 && n < 50);
      if (hrdy !== 1'b1) begin
         fail_count++;
         final_report;
      end
   endtask

   // One single transfer, then one idle edge
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_rdy;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy;
      rdata = hrdata;
      @(posedge clk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask

   // Settle, then compare {ff, dbi, rdy, inp, sa, vlc, tlc}
   task st(input logic [6:0] exp);
      repeat (6) @(posedge clk);
      check({25'h0, ff, dbi, rdy, inp, sa, speed_limiting, torque_limiting}, {25'h0, exp});
   endtask

   task t_powerup;
      int n;
      n = 0;
      while (ff !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, n <= 24}, 32'h1);
      if (ff !== 1'b1) begin
         final_report;
      end
   endtask

   task t_regs;
      rd_chk(`SSO_INPOS_OFS, 32'h64);
      rd_chk(`SSO_BAND_OFS, 32'h0a);
      rd_chk(`SSO_FTRQ_OFS, 32'h7fff);
      rd_chk(`SSO_RTRQ_OFS, 32'h7fff);
      rd_chk(`SSO_SLIM_OFS, 32'hbb8);
      rd_chk(8'h30, 32'h0);
      rd_chk(`SSO_ICLR_OFS, 32'h0);
      wr(`SSO_CTRL_OFS, 32'h3);
      rd_chk(`SSO_CTRL_OFS, 32'h0);
      rd_chk(`SSO_STAT_OFS, 32'h3);
   endtask

   task t_fault;
      wr(`SSO_IEN_OFS, 32'h1f);
      trip <= 1'b1;
      st(7'b0100000);
      check({31'h0, irq}, 32'h1);
      rd_chk(`SSO_ISTAT_OFS, 32'h1);
      wr(`SSO_ICLR_OFS, 32'h1f);
      @(posedge clk);
      check({31'h0, irq}, 32'h0);
      trip <= 1'b0;
      pwr <= 1'b0;
      st(7'b0100000);
      pwr <= 1'b1;
      repeat (30) @(posedge clk);
      st(7'b1100000);
      wr(`SSO_IEN_OFS, 32'h0);
      trip <= 1'b1;
      st(7'b0100000);
      check({31'h0, irq}, 32'h0);
      rd_chk(`SSO_ISTAT_OFS, 32'h1);
      wr(`SSO_ICLR_OFS, 32'h1f);
      trip <= 1'b0;
      st(7'b1100000);
   endtask

   task t_brake;
      brk <= 1'b1;
      st(7'b1000000);
      check({31'h0, dboe}, 32'h0);
      wr(`SSO_CTRL_OFS, 32'h4);
      @(posedge clk);
      check({31'h0, dboe}, 32'h1);
      brk <= 1'b0;
      st(7'b1100000);
   endtask

   task t_pos;
      logic seen;
      seen = 1'b0;
      droop <= 16'sd1000;
      servo_on_request <= 1'b1;
      repeat (8) begin
         @(posedge clk);
         if (inp === 1'b1)
            seen = 1'b1;
      end
      check({31'h0, seen}, 32'h1);
      st(7'b1110000);
      droop <= -16'sd100;
      st(7'b1111000);
      droop <= 16'sd101;
      st(7'b1110000);
      prep <= 1'b0;
      st(7'b1100000);
      prep <= 1'b1;
      droop <= 16'sd0;
      st(7'b1111000);
   endtask

   task t_speed;
      wr(`SSO_CTRL_OFS, 32'h5);
      pre <= 16'sd1000;
      spd <= 16'sd1010;
      fwd <= 1'b1;
      st(7'b1110100);
      spd <= 16'sd1011;
      st(7'b1110000);
      spd <= 16'sd990;
      fwd <= 1'b0;
      rev <= 1'b1;
      st(7'b1110100);
      rev <= 1'b0;
      st(7'b1110000);
      pre <= 16'sd20;
      spd <= 16'sd0;
      st(7'b1110100);
      pre <= 16'sd21;
      st(7'b1110000);
      pre <= 16'sd20;
      servo_on_request <= 1'b0;
      st(7'b1100000);
      servo_on_request <= 1'b1;
   endtask

   task t_trq;
      wr(`SSO_CTRL_OFS, 32'h6);
      trq <= 16'sh7fff;
      aspd <= 16'd500;
      spd <= -16'sd500;
      st(7'b1110010);
      spd <= 16'sd499;
      st(7'b1110000);
      for (int i = 1; i <= 7; i++) begin
         wr(`SSO_SPDSEL_OFS, 32'(i));
         wr(8'(`SSO_SLIM_OFS + 4 * (i - 1)), 32'(100 * i));
         spd <= 16'(100 * i);
         st(7'b1110010);
         spd <= 16'(100 * i - 1);
         st(7'b1110000);
      end
      spd <= 16'sd700;
      servo_on_request <= 1'b0;
      st(7'b1100000);
      servo_on_request <= 1'b1;
   endtask

   task t_torque;
      trq <= 16'sd0;
      droop <= 16'sd1000;
      wr(`SSO_CTRL_OFS, 32'h4);
      wr(`SSO_FTRQ_OFS, 32'd1000);
      wr(`SSO_RTRQ_OFS, 32'd2000);
      trq <= 16'sd1000;
      st(7'b1110001);
      trq <= 16'sd999;
      st(7'b1110000);
      trq <= -16'sd1999;
      st(7'b1110000);
      trq <= -16'sd2000;
      st(7'b1110001);
      wr(`SSO_CTRL_OFS, 32'hc);
      atrq <= 16'd100;
      trq <= 16'sd100;
      st(7'b1110001);
      trq <= 16'sd99;
      st(7'b1110000);
      rd_chk(`SSO_ISTAT_OFS, 32'h1e);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      final_report;
   end

   initial begin
      {clk, nrst, hsel, hwrite, servo_on_request, fwd, rev, trip, brk} = 9'h0;
      {pwr, prep} = 2'b11;
      {haddr, hwdata, htrans} = 66'h0;
      {droop, spd, pre, trq, aspd, atrq} = 96'h0;
      fail_count = 0;
      samples_checked = 0;
      repeat (16) @(posedge clk);
      check({28'h0, hrdy, hresp, dboe, ff}, 32'h8);
      nrst <= 1'b1;
      t_powerup;
      t_regs;
      t_fault;
      t_brake;
      t_pos;
      t_speed;
      t_trq;
      t_torque;
      final_report;
   end
endmodule

/* sso_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs
// Assumes a single clock with a synchronous active-low reset
`timescale 1ns/1ps
module sso_sync #(
   parameter int W = 3
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   // Data
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sso_sync_t;

   sso_sync_t r;
   sso_sync_t r_nxt;

   always_comb begin
      r_nxt    = r;
      r_nxt.s1 = i_d;
      r_nxt.s2 = r.s1;
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign o_q = r.s2;
endmodule
